// ==== hw/pci_primary_claim_termination_ctrl.sv ====
// Operation
// R1: claim as target only for addresses inside the positive decode window.
// R2: as initiator, master abort if no claim within five cycles of frame.
// R3: release claim, stop, parity-error lines by driving high one cycle first.
// R4: stop with trdy and devsel is a disconnect that still transfers data.
// R5: stop and devsel without trdy is disconnect without data; first phase is retry.
// R6: stop without devsel is a target abort ending the transaction.
// R7: a locking initiator keeps lock high in address phase, low one cycle later.
// R8: as target, sample lock and hold the locked state for the secondary side.
// R9: never drive the primary lock line as initiator.
// R10: claim a type 0 configuration cycle when idsel is high at address.
// R11: signal a data parity error two cycles after data, one after parity.
// R12: parity error is driven by target on writes, initiator on reads.
// R13: parity is even over 36 bits, driven a cycle after those bits.
// R14: on master abort drop frame first, then release irdy, record the abort.
`timescale 1ns/1ps
module pci_primary_claim_termination_ctrl
#(
	parameter logic [2:0] DEVSEL_TIMEOUT = pci_claim_pkg::DEVSEL_TIMEOUT_CYC
)
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// primary bus levels
	input wire logic frame_n_i,
	input wire logic irdy_n_i,
	input wire logic trdy_n_i,
	input wire logic devsel_n_i,
	input wire logic stop_n_i,
	input wire logic lock_n_i,
	input wire logic idsel_i,
	input wire logic [pci_claim_pkg::AD_W-1:0] ad_i,
	input wire logic [pci_claim_pkg::CBE_W-1:0] cbe_n_i,
	input wire logic par_i,
	// target decode window
	input wire logic win_en_i,
	input wire logic [pci_claim_pkg::AD_W-1:0] win_base_i,
	input wire logic [pci_claim_pkg::AD_W-1:0] win_limit_i,
	// target termination requests
	input wire logic tgt_stop_i,
	input wire logic tgt_abort_i,
	// initiator requests
	input wire logic mst_start_i,
	input wire logic mst_last_i,
	input wire logic mst_write_i,
	input wire logic mst_abort_clr_i,
	// values this device drives on ad and cbe
	input wire logic [pci_claim_pkg::AD_W-1:0] drv_ad_i,
	input wire logic [pci_claim_pkg::CBE_W-1:0] drv_cbe_n_i,
	input wire logic drv_oe_i,
	// bus drivers
	output logic frame_n_o,
	output logic frame_oe_o,
	output logic irdy_n_o,
	output logic irdy_oe_o,
	output logic devsel_n_o,
	output logic devsel_oe_o,
	output logic stop_n_o,
	output logic stop_oe_o,
	output logic perr_n_o,
	output logic perr_oe_o,
	output logic par_o,
	output logic par_oe_o,
	// status
	output logic term_valid_o,
	output pci_claim_pkg::term_type term_code_o,
	output logic mst_busy_o,
	output logic mst_abort_seen_o,
	output logic tgt_busy_o,
	output logic tgt_write_o,
	output logic tgt_locked_o
);
	import pci_claim_pkg::*;

	typedef enum logic [2:0] {M_IDLE, M_ADDR, M_DATA, M_LAST, M_REL} mst_state_type;
	typedef enum logic [1:0] {T_IDLE, T_BUSY, T_REL} tgt_state_type;

	logic frame_prev_reg;
	tgt_state_type t_state_reg, t_state_next;
	logic devsel_n_reg, devsel_n_next, devsel_oe_reg, devsel_oe_next;
	logic stop_n_reg, stop_n_next, stop_oe_reg, stop_oe_next;
	logic tgt_write_reg, tgt_write_next, lock_chk_reg, lock_chk_next;
	logic locked_reg, locked_next;
	mst_state_type m_state_reg, m_state_next;
	logic frame_n_reg, frame_n_next, frame_oe_reg, frame_oe_next;
	logic irdy_n_reg, irdy_n_next, irdy_oe_reg, irdy_oe_next;
	logic [2:0] cnt_reg, cnt_next;
	logic seen_reg, seen_next, first_reg, first_next, end_pend_reg, end_pend_next;
	logic term_valid_reg, term_valid_next, abort_seen_reg, abort_seen_next;
	term_type term_code_reg, term_code_next;
	logic perr_n_reg, perr_n_next, perr_oe_reg, perr_oe_next;
	logic addr_phase, cfg_hit, mem_hit, claim_hit, last_done;
	logic claimed, xfer, mabort_now, rx_check, par_err, exp_par, drv_par;
	term_type t_dec;

	// ****************************************
	// decode
	// ****************************************
	assign addr_phase = !frame_n_i && frame_prev_reg && (m_state_reg == M_IDLE);
	// R10: type 0 configuration select
	assign cfg_hit = idsel_i && ((cbe_n_i == CMD_CFG_RD) || (cbe_n_i == CMD_CFG_WR))
		&& (ad_i[1:0] == CFG_TYPE0);
	// R1: positive address decode
	assign mem_hit = win_en_i && is_mem_cmd(cbe_n_i) && (ad_i >= win_base_i)
		&& (ad_i <= win_limit_i);
	assign claim_hit = cfg_hit || mem_hit;
	assign last_done = frame_n_i && !irdy_n_i && (!trdy_n_i || !stop_n_i);
	assign claimed = seen_reg || !devsel_n_i;
	assign xfer = !irdy_n_reg && !trdy_n_i && claimed;
	// R2: no claim by the timeout
	assign mabort_now = !seen_reg && devsel_n_i && (cnt_reg == DEVSEL_TIMEOUT);
	// R4: termination decode
	assign t_dec = decode_term(trdy_n_i, stop_n_i, devsel_n_i, first_reg);
	// R12: receiver of data checks
	assign rx_check = ((t_state_reg == T_BUSY) && tgt_write_reg && !irdy_n_i && !trdy_n_i)
		|| (((m_state_reg == M_DATA) || (m_state_reg == M_LAST)) && !mst_write_i && xfer);
	assign exp_par = even_par(ad_i, cbe_n_i);
	assign drv_par = even_par(drv_ad_i, drv_cbe_n_i);

	pci_parity_unit u_parity (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ad_i(ad_i),
		.cbe_n_i(cbe_n_i),
		.par_i(par_i),
		.chk_i(rx_check),
		.drv_ad_i(drv_ad_i),
		.drv_cbe_n_i(drv_cbe_n_i),
		.drv_oe_i(drv_oe_i),
		.err_o(par_err),
		.par_o(par_o),
		.par_oe_o(par_oe_o)
	);

	// ****************************************
	// target side
	// ****************************************
	always_comb
	begin
		t_state_next = t_state_reg;
		devsel_n_next = devsel_n_reg;
		devsel_oe_next = devsel_oe_reg;
		stop_n_next = stop_n_reg;
		stop_oe_next = stop_oe_reg;
		tgt_write_next = tgt_write_reg;
		lock_chk_next = 1'b0;
		locked_next = locked_reg;
		// lock ends once it is high while frame is high
		if (locked_reg && lock_n_i && frame_n_i)
			locked_next = 1'b0;
		unique case (t_state_reg)
			T_IDLE:
			begin
				devsel_oe_next = 1'b0;
				stop_oe_next = 1'b0;
				// R1: claim on decode hit
				if (addr_phase && claim_hit)
				begin
					t_state_next = T_BUSY;
					devsel_n_next = 1'b0;
					devsel_oe_next = 1'b1;
					stop_n_next = 1'b1;
					stop_oe_next = 1'b1;
					tgt_write_next = cbe_n_i[CMD_WRITE_BIT];
					// R7: lock high in address phase
					lock_chk_next = lock_n_i;
				end
			end
			T_BUSY:
			begin
				// R8: lock taken one cycle later
				if (lock_chk_reg && !lock_n_i)
					locked_next = 1'b1;
				// R6: abort drops devsel, keeps stop
				devsel_n_next = devsel_n_reg || tgt_abort_i;
				stop_n_next = stop_n_reg && !(tgt_stop_i || tgt_abort_i);
				// R3: drive high one cycle
				if (last_done || (frame_n_i && irdy_n_i))
				begin
					t_state_next = T_REL;
					devsel_n_next = 1'b1;
					stop_n_next = 1'b1;
				end
			end
			T_REL:
			begin
				t_state_next = T_IDLE;
				devsel_oe_next = 1'b0;
				stop_oe_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			frame_prev_reg <= 1'b1;
			t_state_reg <= T_IDLE;
			devsel_n_reg <= 1'b1;
			devsel_oe_reg <= 1'b0;
			stop_n_reg <= 1'b1;
			stop_oe_reg <= 1'b0;
			tgt_write_reg <= 1'b0;
			lock_chk_reg <= 1'b0;
			locked_reg <= 1'b0;
		end
		else
		begin
			frame_prev_reg <= frame_n_i;
			t_state_reg <= t_state_next;
			devsel_n_reg <= devsel_n_next;
			devsel_oe_reg <= devsel_oe_next;
			stop_n_reg <= stop_n_next;
			stop_oe_reg <= stop_oe_next;
			tgt_write_reg <= tgt_write_next;
			lock_chk_reg <= lock_chk_next;
			locked_reg <= locked_next;
		end
	end

	// ****************************************
	// initiator side
	// ****************************************
	always_comb
	begin
		m_state_next = m_state_reg;
		frame_n_next = frame_n_reg;
		frame_oe_next = frame_oe_reg;
		irdy_n_next = irdy_n_reg;
		irdy_oe_next = irdy_oe_reg;
		cnt_next = cnt_reg;
		seen_next = seen_reg;
		first_next = first_reg;
		end_pend_next = end_pend_reg;
		term_valid_next = 1'b0;
		term_code_next = term_code_reg;
		abort_seen_next = abort_seen_reg && !mst_abort_clr_i;
		if ((m_state_reg != M_IDLE) && (m_state_reg != M_REL))
		begin
			seen_next = seen_reg || !devsel_n_i;
			if (cnt_reg < DEVSEL_TIMEOUT)
				cnt_next = 3'(cnt_reg + 3'h1);
		end
		unique case (m_state_reg)
			M_IDLE:
			begin
				if (mst_start_i)
				begin
					m_state_next = M_ADDR;
					frame_n_next = 1'b0;
					frame_oe_next = 1'b1;
					irdy_n_next = 1'b1;
					irdy_oe_next = 1'b1;
					cnt_next = 3'h0;
					seen_next = 1'b0;
					first_next = 1'b1;
					end_pend_next = 1'b0;
				end
			end
			M_ADDR:
			begin
				irdy_n_next = 1'b0;
				frame_n_next = mst_last_i;
				m_state_next = mst_last_i ? M_LAST : M_DATA;
			end
			M_DATA:
			begin
				if (mabort_now)
				begin
					// R14: frame first, irdy after
					m_state_next = M_LAST;
					frame_n_next = 1'b1;
					end_pend_next = 1'b1;
					term_valid_next = 1'b1;
					term_code_next = TERM_MABORT;
					abort_seen_next = 1'b1;
				end
				// R5: stop ends the transaction
				else if ((t_dec != TERM_NONE) && claimed)
				begin
					m_state_next = M_LAST;
					frame_n_next = 1'b1;
					end_pend_next = 1'b1;
					term_valid_next = 1'b1;
					term_code_next = t_dec;
				end
				else
				begin
					if (xfer)
						first_next = 1'b0;
					if (mst_last_i)
					begin
						m_state_next = M_LAST;
						frame_n_next = 1'b1;
					end
				end
			end
			M_LAST:
			begin
				if (end_pend_reg || mabort_now || ((t_dec != TERM_NONE) && claimed) || xfer)
				begin
					m_state_next = M_REL;
					frame_oe_next = 1'b0;
					irdy_n_next = 1'b1;
				end
				if (!end_pend_reg)
				begin
					// R2: abort after frame is already high
					if (mabort_now)
					begin
						term_valid_next = 1'b1;
						term_code_next = TERM_MABORT;
						abort_seen_next = 1'b1;
					end
					// R6: abort or disconnect in final phase
					else if ((t_dec != TERM_NONE) && claimed)
					begin
						term_valid_next = 1'b1;
						term_code_next = t_dec;
					end
					else if (xfer)
					begin
						term_valid_next = 1'b1;
						term_code_next = TERM_DONE;
					end
				end
			end
			M_REL:
			begin
				m_state_next = M_IDLE;
				irdy_oe_next = 1'b0;
				frame_oe_next = 1'b0;
				end_pend_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			m_state_reg <= M_IDLE;
			frame_n_reg <= 1'b1;
			frame_oe_reg <= 1'b0;
			irdy_n_reg <= 1'b1;
			irdy_oe_reg <= 1'b0;
			cnt_reg <= 3'h0;
			seen_reg <= 1'b0;
			first_reg <= 1'b0;
			end_pend_reg <= 1'b0;
			term_valid_reg <= 1'b0;
			term_code_reg <= TERM_NONE;
			abort_seen_reg <= 1'b0;
		end
		else
		begin
			m_state_reg <= m_state_next;
			frame_n_reg <= frame_n_next;
			frame_oe_reg <= frame_oe_next;
			irdy_n_reg <= irdy_n_next;
			irdy_oe_reg <= irdy_oe_next;
			cnt_reg <= cnt_next;
			seen_reg <= seen_next;
			first_reg <= first_next;
			end_pend_reg <= end_pend_next;
			term_valid_reg <= term_valid_next;
			term_code_reg <= term_code_next;
			abort_seen_reg <= abort_seen_next;
		end
	end

	// ****************************************
	// parity error line
	// ****************************************
	always_comb
	begin
		perr_n_next = 1'b1;
		perr_oe_next = 1'b0;
		// R11: error two cycles after data
		if (par_err)
		begin
			perr_n_next = 1'b0;
			perr_oe_next = 1'b1;
		end
		// R3: one high cycle before release
		else if (perr_oe_reg && !perr_n_reg)
			perr_oe_next = 1'b1;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			perr_n_reg <= 1'b1;
			perr_oe_reg <= 1'b0;
		end
		else
		begin
			perr_n_reg <= perr_n_next;
			perr_oe_reg <= perr_oe_next;
		end
	end

	// R9: lock is input only, no driver
	assign frame_n_o = frame_n_reg;
	assign frame_oe_o = frame_oe_reg;
	assign irdy_n_o = irdy_n_reg;
	assign irdy_oe_o = irdy_oe_reg;
	assign devsel_n_o = devsel_n_reg;
	assign devsel_oe_o = devsel_oe_reg;
	assign stop_n_o = stop_n_reg;
	assign stop_oe_o = stop_oe_reg;
	assign perr_n_o = perr_n_reg;
	assign perr_oe_o = perr_oe_reg;
	assign term_valid_o = term_valid_reg;
	assign term_code_o = term_code_reg;
	assign mst_busy_o = frame_oe_reg;
	assign mst_abort_seen_o = abort_seen_reg;
	assign tgt_busy_o = devsel_oe_reg;
	assign tgt_write_o = tgt_write_reg;
	assign tgt_locked_o = locked_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_lock_open;
		(t_state_reg == T_IDLE && addr_phase && claim_hit && lock_n_i) ##1 !lock_n_i;
	endsequence
	sequence s_bad_data;
		rx_check ##1 (par_i != $past(exp_par));
	endsequence
	sequence s_abort_release;
		(frame_n_o && frame_oe_o && !irdy_n_o) ##1 (irdy_n_o && !frame_oe_o && irdy_oe_o)
			##1 !irdy_oe_o;
	endsequence

	property p_claim_cause;
		$rose(devsel_oe_o) |-> ($past(claim_hit) && !devsel_n_o);
	endproperty
	a_claim_cause: assert property (p_claim_cause) else $error("claim without decode hit"); // R1
	property p_cfg_claim;
		(t_state_reg == T_IDLE && addr_phase && cfg_hit) |=> (devsel_oe_o && !devsel_n_o);
	endproperty
	a_cfg_claim: assert property (p_cfg_claim) else $error("config select not claimed"); // R10
	property p_mabort;
		(m_state_reg == M_ADDR) ##1 (devsel_n_i [*5]) |=>
			(term_valid_o && term_code_o == TERM_MABORT);
	endproperty
	a_mabort: assert property (p_mabort) else $error("missing master abort"); // R2
	property p_devsel_rel;
		$fell(devsel_oe_o) |-> ($past(devsel_n_o) && $past(stop_n_o));
	endproperty
	a_devsel_rel: assert property (p_devsel_rel) else $error("devsel released low"); // R3
	property p_perr_rel;
		$fell(perr_oe_o) |-> ($past(perr_n_o) && !$past(perr_n_o, 2));
	endproperty
	a_perr_rel: assert property (p_perr_rel) else $error("perr release not one cycle"); // R3
	property p_disc_data;
		(term_valid_o && term_code_o == TERM_DISC_DATA) |->
			(!$past(trdy_n_i) && !$past(stop_n_i) && !$past(devsel_n_i));
	endproperty
	a_disc_data: assert property (p_disc_data) else $error("bad disconnect decode"); // R4
	property p_retry;
		(term_valid_o && term_code_o == TERM_RETRY) |->
			($past(first_reg) && $past(trdy_n_i) && !$past(stop_n_i) && !$past(devsel_n_i));
	endproperty
	a_retry: assert property (p_retry) else $error("bad retry decode"); // R5
	property p_tabort;
		(term_valid_o && term_code_o == TERM_TABORT) |-> ($past(devsel_n_i) && !$past(stop_n_i));
	endproperty
	a_tabort: assert property (p_tabort) else $error("bad target abort decode"); // R6
	property p_lock;
		s_lock_open |=> tgt_locked_o;
	endproperty
	a_lock: assert property (p_lock) else $error("lock not taken"); // R8
	property p_perr;
		s_bad_data |=> (!perr_n_o && perr_oe_o);
	endproperty
	a_perr: assert property (p_perr) else $error("parity error not signalled"); // R11
	property p_perr_owner;
		(perr_oe_o && !perr_n_o) |-> $past(rx_check, 2);
	endproperty
	a_perr_owner: assert property (p_perr_owner) else $error("perr from non receiver"); // R12
	property p_par_gen;
		drv_oe_i |=> (par_oe_o && (par_o == $past(drv_par)));
	endproperty
	a_par_gen: assert property (p_par_gen) else $error("parity output wrong"); // R13
	property p_abort_seq;
		(m_state_reg == M_DATA && mabort_now) |=> s_abort_release;
	endproperty
	a_abort_seq: assert property (p_abort_seq) else $error("abort release order wrong"); // R14

endmodule

// ==== hw/pci_claim_pkg.sv ====
package pci_claim_pkg;

	// ****************************************
	// bus widths and command codes
	// ****************************************
	localparam int AD_W = 32;
	localparam int CBE_W = 4;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	localparam logic [3:0] CMD_MEM_RDM = 4'hc;
	localparam logic [3:0] CMD_MEM_RDL = 4'he;
	localparam logic [3:0] CMD_MEM_WRI = 4'hf;
	localparam int CMD_WRITE_BIT = 0;
	localparam logic [1:0] CFG_TYPE0 = 2'h0;

	// ****************************************
	// timing
	// ****************************************
	localparam logic [2:0] DEVSEL_TIMEOUT_CYC = 3'h5;

	// ****************************************
	// termination results
	// ****************************************
	typedef enum logic [2:0] {
		TERM_NONE,
		TERM_DONE,
		TERM_DISC_DATA,
		TERM_DISC_NODATA,
		TERM_RETRY,
		TERM_TABORT,
		TERM_MABORT
	} term_type;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic even_par(input logic [AD_W-1:0] ad, input logic [CBE_W-1:0] cbe);
		even_par = ^{ad, cbe};
	endfunction

	function automatic logic is_mem_cmd(input logic [CBE_W-1:0] cmd);
		is_mem_cmd = (cmd == CMD_MEM_RD) || (cmd == CMD_MEM_WR) || (cmd == CMD_MEM_RDM)
			|| (cmd == CMD_MEM_RDL) || (cmd == CMD_MEM_WRI);
	endfunction

	function automatic term_type decode_term(input logic trdy_n, input logic stop_n,
		input logic devsel_n, input logic first);
		if (stop_n)
			decode_term = TERM_NONE;
		else if (devsel_n)
			decode_term = TERM_TABORT;
		else if (!trdy_n)
			decode_term = TERM_DISC_DATA;
		else if (first)
			decode_term = TERM_RETRY;
		else
			decode_term = TERM_DISC_NODATA;
	endfunction

endpackage

// ==== hw/pci_parity_unit.sv ====
`timescale 1ns/1ps
module pci_parity_unit
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// received bus
	input wire logic [pci_claim_pkg::AD_W-1:0] ad_i,
	input wire logic [pci_claim_pkg::CBE_W-1:0] cbe_n_i,
	input wire logic par_i,
	input wire logic chk_i,
	// driven bus
	input wire logic [pci_claim_pkg::AD_W-1:0] drv_ad_i,
	input wire logic [pci_claim_pkg::CBE_W-1:0] drv_cbe_n_i,
	input wire logic drv_oe_i,
	// results
	output logic err_o,
	output logic par_o,
	output logic par_oe_o
);
	import pci_claim_pkg::*;

	logic exp_reg;
	logic exp_next;
	logic chk_reg;
	logic chk_next;
	logic par_reg;
	logic par_next;
	logic par_oe_reg;
	logic par_oe_next;

	always_comb
	begin
		exp_next = even_par(ad_i, cbe_n_i);
		chk_next = chk_i;
		// R13: parity one cycle later
		par_next = even_par(drv_ad_i, drv_cbe_n_i);
		par_oe_next = drv_oe_i;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			exp_reg <= 1'b0;
			chk_reg <= 1'b0;
			par_reg <= 1'b0;
			par_oe_reg <= 1'b0;
		end
		else
		begin
			exp_reg <= exp_next;
			chk_reg <= chk_next;
			par_reg <= par_next;
			par_oe_reg <= par_oe_next;
		end
	end

	// R11: compare sampled parity bit
	assign err_o = chk_reg && (par_i != exp_reg);
	assign par_o = par_reg;
	assign par_oe_o = par_oe_reg;

endmodule

// ==== tb/pci_far_agent.sv ====
`timescale 1ns/1ps
module pci_far_agent
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// behaviour select
	input wire logic [2:0] mode_i,
	input wire logic [1:0] wait_i,
	// resolved bus
	input wire logic frame_n_i,
	input wire logic irdy_n_i,
	// target lines, pull-up level when not active
	output logic trdy_n_o,
	output logic devsel_n_o,
	output logic stop_n_o
);
	logic frame_prev_reg;
	logic act_reg;
	logic [1:0] cnt_reg;
	logic [3:0] step_reg;

	// ****************************************
	// target answering the initiator
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			frame_prev_reg <= 1'b1;
			act_reg <= 1'b0;
			cnt_reg <= 2'h0;
			step_reg <= 4'h0;
		end
		else
		begin
			frame_prev_reg <= frame_n_i;
			if (act_reg)
			begin
				step_reg <= step_reg + 4'h1;
				if (frame_n_i && (irdy_n_i || !trdy_n_o || !stop_n_o))
					act_reg <= 1'b0;
			end
			else if (cnt_reg != 2'h0)
			begin
				cnt_reg <= cnt_reg - 2'h1;
				act_reg <= (cnt_reg == 2'h1);
				step_reg <= 4'h0;
			end
			else if (frame_prev_reg && !frame_n_i && mode_i != 3'h0)
			begin
				cnt_reg <= wait_i;
				act_reg <= (wait_i == 2'h0);
				step_reg <= 4'h0;
			end
		end
	end

	always_comb
	begin
		trdy_n_o = 1'b1;
		devsel_n_o = 1'b1;
		stop_n_o = 1'b1;
		if (act_reg)
		begin
			devsel_n_o = (mode_i == 3'h4) && (step_reg != 4'h0);
			trdy_n_o = !(mode_i == 3'h1 || mode_i == 3'h3 || (mode_i == 3'h5 && step_reg == 4'h0));
			stop_n_o = !(mode_i == 3'h2 || mode_i == 3'h3 || (mode_i >= 3'h4 && step_reg != 4'h0));
		end
	end
endmodule

// ==== tb/tb_pci_primary_claim_termination_ctrl.sv ====
`timescale 1ns/1ps
module tb_pci_primary_claim_termination_ctrl;
	import pci_claim_pkg::*;
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0, fr_n = 1'b1, ir_n = 1'b1, tr_n = 1'b1;
	logic lock_n_i = 1'b1, idsel_i = 1'b0, win_en_i = 1'b0, bad_par = 1'b0, tb_par = 1'b0;
	logic mst_start_i = 1'b0, mst_last_i = 1'b0, mst_write_i = 1'b0, mst_abort_clr_i = 1'b0;
	logic drv_oe_i = 1'b0, p_oe, p_par;
	logic [3:0] cbe_n_i = 4'h0, drv_cbe_n_i = 4'h0;
	logic [31:0] ad_i = 32'h0, drv_ad_i = 32'h0;
	logic [2:0] mode = 3'h0;
	logic [1:0] wt = 2'h0;
	logic [1:0] t_req = 2'h0;
	logic frame_n_o, frame_oe_o, irdy_n_o, irdy_oe_o, devsel_n_o, devsel_oe_o, stop_n_o, stop_oe_o;
	logic perr_n_o, perr_oe_o, par_o, par_oe_o, term_valid_o, mst_busy_o, mst_abort_seen_o;
	logic tgt_busy_o, tgt_write_o, tgt_locked_o, p_trdy, p_devsel, p_stop;
	term_type term_code_o;
	term_type exp_q[$];
	int failures = 0, check_count = 0, cyc = 0, perr_cnt = 0;
	int seed = 32'heea73a87;
	wire logic frame_bus = frame_oe_o ? frame_n_o : fr_n;
	wire logic irdy_bus = irdy_oe_o ? irdy_n_o : ir_n;
	wire logic devsel_bus = devsel_oe_o ? devsel_n_o : p_devsel;
	wire logic stop_bus = stop_oe_o ? stop_n_o : p_stop;
	wire logic par_bus = par_oe_o ? par_o : tb_par;

	pci_primary_claim_termination_ctrl pci_primary_claim_termination_ctrl_i (
		.clk_sys_i, .rst_n_i, .frame_n_i(frame_bus), .irdy_n_i(irdy_bus),
		.trdy_n_i(p_trdy & tr_n), .devsel_n_i(devsel_bus), .stop_n_i(stop_bus), .lock_n_i,
		.idsel_i, .ad_i, .cbe_n_i, .par_i(par_bus), .win_en_i, .win_base_i(32'h1000_0000),
		.win_limit_i(32'h1000_ffff), .tgt_stop_i(t_req[0]), .tgt_abort_i(t_req[1]),
		.mst_start_i,
		.mst_last_i, .mst_write_i, .mst_abort_clr_i, .drv_ad_i, .drv_cbe_n_i, .drv_oe_i,
		.frame_n_o, .frame_oe_o, .irdy_n_o, .irdy_oe_o, .devsel_n_o, .devsel_oe_o, .stop_n_o,
		.stop_oe_o, .perr_n_o, .perr_oe_o, .par_o, .par_oe_o, .term_valid_o, .term_code_o,
		.mst_busy_o, .mst_abort_seen_o, .tgt_busy_o, .tgt_write_o, .tgt_locked_o);

	pci_far_agent pci_far_agent_i (.clk_sys_i, .rst_n_i, .mode_i(mode), .wait_i(wt),
		.frame_n_i(frame_bus), .irdy_n_i(irdy_bus), .trdy_n_o(p_trdy), .devsel_n_o(p_devsel),
		.stop_n_o(p_stop));

	initial forever #10 clk_sys_i = ~clk_sys_i;

	// ****************************************
	// checking and reporting
	// ****************************************
	task automatic chk(input string what, input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	task automatic chk_term(input term_type got, input term_type exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: term code %0d", $time, got);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// far side parity, one cycle after data
	always @(posedge clk_sys_i)
	begin
		cyc++;
		tb_par <= ^{ad_i, cbe_n_i} ^ bad_par;
		if (perr_oe_o === 1'b1 && perr_n_o === 1'b0)
			perr_cnt++;
		if (term_valid_o === 1'b1 && exp_q.size() == 0)
			chk("unexpected result", 1'b1, 1'b0);
		else if (term_valid_o === 1'b1)
			chk_term(term_code_o, exp_q.pop_front());
		if (cyc == 2000)
		begin
			failures++;
			report_and_stop();
		end
	end

	// ****************************************
	// scenarios
	// ****************************************
	task automatic tick;
		@(posedge clk_sys_i);
		#1;
	endtask

	task automatic tgt_case(input logic [3:0] cmd, input logic [31:0] a, input logic sel,
		input logic we, input logic hit, input logic bad);
		logic wr;
		wr = hit && cmd[0];
		@(posedge clk_sys_i);
		fr_n <= 1'b0;
		ad_i <= a;
		cbe_n_i <= cmd;
		idsel_i <= sel;
		win_en_i <= we;
		@(posedge clk_sys_i);
		fr_n <= 1'b1;
		ir_n <= 1'b0;
		tr_n <= 1'b0;
		lock_n_i <= 1'b0;
		bad_par <= bad;
		ad_i <= $random(seed);
		#1;
		chk("claim", devsel_n_o, !hit);
		chk("claim drive", devsel_oe_o, hit);
		chk("no stop", stop_n_o, 1'b1);
		if (hit)
			chk("write flag", tgt_write_o, wr);
		@(posedge clk_sys_i);
		ir_n <= 1'b1;
		tr_n <= 1'b1;
		lock_n_i <= 1'b1;
		bad_par <= 1'b0;
		#1;
		if (hit)
			chk("locked", tgt_locked_o, 1'b1);
		chk("claim release", devsel_n_o, 1'b1);
		chk("claim release drive", devsel_oe_o, hit);
		chk("stop release drive", stop_oe_o, hit);
		tick();
		chk("perr", perr_n_o, !(bad && wr));
		chk("perr drive", perr_oe_o, bad && wr);
		chk("claim idle", devsel_oe_o | stop_oe_o, 1'b0);
		chk("lock clear", tgt_locked_o, 1'b0);
		tick();
		chk("perr release", perr_n_o, 1'b1);
		chk("perr release drive", perr_oe_o, bad && wr);
		tick();
		chk("perr idle", perr_oe_o, 1'b0);
		$display("target case cmd %h done", cmd);
	endtask

	task automatic mst_case(input logic [2:0] m, input logic [1:0] w, input logic last,
		input logic wr, input logic bad, input term_type code, input int cyc_n);
		int n;
		@(posedge clk_sys_i);
		mode <= m;
		wt <= w;
		mst_last_i <= last;
		mst_write_i <= wr;
		bad_par <= bad;
		mst_start_i <= 1'b1;
		exp_q.push_back(code);
		perr_cnt = 0;
		n = 0;
		do
		begin
			@(posedge clk_sys_i);
			mst_start_i <= 1'b0;
			n++;
			#1;
		end
		while (term_valid_o !== 1'b1 && n < 40);
		if (cyc_n != 0)
		begin
			chk("abort time", n == cyc_n, 1'b1);
			chk("frame first", frame_n_o, 1'b1);
			chk("irdy held", irdy_n_o, 1'b0);
			chk("abort seen", mst_abort_seen_o, 1'b1);
			tick();
			chk("frame off", frame_oe_o, 1'b0);
			chk("irdy high", irdy_n_o & irdy_oe_o, 1'b1);
		end
		@(posedge clk_sys_i);
		mode <= 3'h0;
		bad_par <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk("bus free", frame_oe_o | irdy_oe_o, 1'b0);
		chk("perr count", perr_cnt == (bad && !wr), 1'b1);
		$display("initiator case mode %0d done", m);
	endtask

	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		tgt_case(4'h6, 32'h1000_0000, 1'b0, 1'b1, 1'b1, 1'b1);
		tgt_case(4'h7, 32'h1000_ffff, 1'b0, 1'b1, 1'b1, 1'b1);
		tgt_case(4'h7, 32'h1001_0000, 1'b0, 1'b1, 1'b0, 1'b1);
		tgt_case(4'h6, 32'h0fff_fffc, 1'b0, 1'b1, 1'b0, 1'b0);
		tgt_case(4'hc, 32'h1000_1230, 1'b0, 1'b1, 1'b1, 1'b0);
		tgt_case(4'he, 32'h1000_4000, 1'b0, 1'b1, 1'b1, 1'b0);
		tgt_case(4'hf, 32'h1000_8000, 1'b0, 1'b1, 1'b1, 1'b0);
		tgt_case(4'h6, 32'h1000_0100, 1'b0, 1'b0, 1'b0, 1'b0);
		tgt_case(4'h2, 32'h1000_0100, 1'b0, 1'b1, 1'b0, 1'b0);
		tgt_case(4'hb, 32'h0000_0104, 1'b1, 1'b0, 1'b1, 1'b1);
		tgt_case(4'ha, 32'h0000_0008, 1'b1, 1'b0, 1'b1, 1'b0);
		tgt_case(4'ha, 32'h0000_0008, 1'b0, 1'b0, 1'b0, 1'b0);
		tgt_case(4'ha, 32'h0000_0009, 1'b1, 1'b0, 1'b0, 1'b0);
		// target side stop (i = 0) and abort (i = 1) with trdy held off
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk_sys_i);
			fr_n <= 1'b0;
			ad_i <= 32'h1000_0040;
			cbe_n_i <= CMD_MEM_RD;
			win_en_i <= 1'b1;
			idsel_i <= 1'b0;
			t_req <= 2'h1 << i;
			@(posedge clk_sys_i);
			fr_n <= 1'b1;
			ir_n <= 1'b0;
			@(posedge clk_sys_i);
			ir_n <= 1'b1;
			t_req <= 2'h0;
			#1;
			chk("tgt stop", stop_n_o | !stop_oe_o, 1'b0);
			chk("tgt abort devsel", devsel_n_o, i[0]);
			tick();
			chk("tgt stop release", stop_n_o & stop_oe_o, 1'b1);
		end
		mst_case(3'h1, 2'h0, 1'b1, 1'b0, 1'b1, TERM_DONE, 0);
		mst_case(3'h1, 2'h2, 1'b1, 1'b1, 1'b1, TERM_DONE, 0);
		mst_case(3'h3, 2'h0, 1'b0, 1'b0, 1'b0, TERM_DISC_DATA, 0);
		mst_case(3'h2, 2'h1, 1'b0, 1'b1, 1'b0, TERM_RETRY, 0);
		mst_case(3'h5, 2'h0, 1'b0, 1'b1, 1'b0, TERM_DISC_NODATA, 0);
		mst_case(3'h4, 2'h0, 1'b0, 1'b0, 1'b0, TERM_TABORT, 0);
		mst_case(3'h0, 2'h0, 1'b0, 1'b0, 1'b0, TERM_MABORT, DEVSEL_TIMEOUT_CYC + 2);
		@(posedge clk_sys_i);
		mst_abort_clr_i <= 1'b1;
		@(posedge clk_sys_i);
		mst_abort_clr_i <= 1'b0;
		#1;
		chk("abort cleared", mst_abort_seen_o, 1'b0);
		repeat (16)
		begin
			@(posedge clk_sys_i);
			p_oe = drv_oe_i;
			p_par = ^{drv_ad_i, drv_cbe_n_i};
			drv_ad_i <= $random(seed);
			drv_cbe_n_i <= $random(seed);
			drv_oe_i <= $random(seed);
			#1;
			chk("par drive", par_oe_o, p_oe);
			if (p_oe)
				chk("par value", par_o, p_par);
		end
		drv_oe_i <= 1'b0;
		$display("parity drive test done");
		chk("results consumed", exp_q.size() == 0, 1'b1);
		report_and_stop();
	end
endmodule
